// >>> hw/lap_pkg.sv
// lap_pkg: constants, register map and carrier types for the LED playback block
// assumes a 100 MHz core clock; all other files import this package whole
package lap_pkg;
  // core clock
  localparam int CLK_HZ = 100_000_000;
  // internal pattern oscillator, modelled as a fractional tick of the core clock
  localparam int OSC_HZ = 16_000_000;
  localparam logic [7:0] OSC_STEP = 8'(OSC_HZ / 1_000_000);
  localparam logic [7:0] OSC_WRAP = 8'(CLK_HZ / 1_000_000);
  // programming link
  localparam int UART_BAUD = 19_200;
  localparam int UART_BIT_CYC = CLK_HZ / UART_BAUD;
  // animation duration unit is one tenth of a second, 1 to 150 units
  localparam int DUR_UNIT_MS = 100;
  localparam int DUR_UNIT_CYC = (CLK_HZ / 1000) * DUR_UNIT_MS;
  localparam logic [7:0] DUR_MIN = 8'h01;
  localparam logic [7:0] DUR_MAX = 8'h96;
  // slowest legal external pattern clock, 100 Hz, gives the missing-clock limit
  localparam int EXT_MIN_HZ = 100;
  localparam int CLK_MISS_CYC = CLK_HZ / EXT_MIN_HZ;
  // short on an output must persist this many cycles before it counts
  localparam logic [3:0] SHORT_FILT = 4'hF;
  // multiplexed drive: half-frame time in cycles
  localparam logic [15:0] MUX_HALF_CYC = 16'h2710;
  // pattern store: four banks, 12 KB each, two bytes per step
  localparam int BANKS = 4;
  localparam int BANK_BYTES = 12 * 1024;
  localparam int MEM_BYTES = BANKS * BANK_BYTES;
  localparam int LEDS = 12;
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PRESCALE = 8'h04;
  localparam logic [7:0] REG_DUTY = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_LOADPTR = 8'h10;
  localparam logic [7:0] REG_DEVADDR = 8'h14;
  localparam logic [7:0] REG_BANK0 = 8'h20;
  // reset values
  localparam logic [15:0] PRESCALE_RST = 16'hFFFF;
  localparam logic [7:0] DUTY_RST = 8'hFF;
  localparam logic [7:0] DEVADDR_RST = 8'h00;
  // drive arrangements of the twelve outputs
  typedef enum logic [1:0] {
    LAP_DRV_CATHODE = 2'b00,
    LAP_DRV_ANODE = 2'b01,
    LAP_DRV_MUX = 2'b10
  } lap_drive_t;
  // per-bank configuration word
  typedef struct packed {
    logic cascade;
    logic [12:0] steps;
    logic [7:0] duration;
  } lap_bank_cfg_t;
  // control word
  typedef struct packed {
    lap_drive_t drive;
    logic allStop;
    logic extClk;
  } lap_ctrl_t;
  // status word
  typedef struct packed {
    logic loadMode;
    logic [1:0] bank;
    logic faultShort;
    logic faultClk;
    logic faultWd;
    logic ended;
    logic playing;
  } lap_status_t;
endpackage

// >>> hw/lap_ctrl.sv
// lap_ctrl: playback control, pattern store, watchdog, fault line and FLASH_LOAD_MODE link
// assumes all pins are already synchronous to clk; fault line resolved outside
//
// Notes on behaviour
// (R1) end output high at final step
// (R2) go pin starts selected pattern
// (R3) four 12 KB banks, pick pins choose
// (R4) load mode: pick0 is RX, pick1 TX
// (R5) 19.2K baud link, dynamic device address
// (R6) external clock must be 100-400 Hz
// (R7) internal 16 MHz clock via prescaler
// (R8) durations from 0.1 s to 15 s
// (R9) watchdog faults late animation end
// (R10) watchdog faults on missing pattern clock
// (R11) output short raises fault
// (R12) open-drain fault line pulled low
// (R13) fault option: all stop or one stops
// (R14) each pattern cascade or synchronous mode
// (R15) end pin ends sync, chains cascade
// (R16) enable low gives low power
// (R17) active-low reset pin, pulled up
// (R18) twelve push-pull outputs, three arrangements
// (R19) programmable duty cycle dimming
// (R20) bytes are 8N1, LSB first
// (R21) pick pins sampled at synced go edge
// (R22) all-stop: halt while fault line low
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/100ps
module lap_ctrl
  import lap_pkg::*;
#(
  parameter int UART_BIT = UART_BIT_CYC,
  parameter int DUR_CYC = DUR_UNIT_CYC,
  parameter int MISS_CYC = CLK_MISS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic resetPinN,
  // playback pins
  input wire logic animation_go_in,
  input wire logic pattern_pick_0,
  input wire logic pattern_pick_1,
  output logic pattern_pick_1Out,
  output logic pattern_pick_1OeN,
  input wire logic flash_load_mode,
  input wire logic external_pattern_clock,
  input wire logic enable,
  output logic animation_end_out,
  // open-drain fault line
  input wire logic fault_line_n,
  output logic faultLineOut,
  output logic faultLineOeN,
  // led outputs and their sensed levels
  output logic [LEDS-1:0] led_drive_outputs,
  input wire logic [LEDS-1:0] ledSense,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata
);

  typedef enum logic [1:0] {
    LAP_IDLE = 2'b00,
    LAP_PLAY = 2'b01,
    LAP_DONE = 2'b10,
    LAP_HALT = 2'b11
  } lap_state_t;

  logic intRst;
  lap_ctrl_t ctrl;
  logic [15:0] prescale;
  logic [7:0] duty;
  logic [15:0] loadPtr;
  logic [7:0] devAddr;
  lap_bank_cfg_t bankCfg [BANKS];
  logic [7:0] mem [MEM_BYTES];
  lap_state_t state;
  lap_status_t status;
  logic [1:0] bank;
  logic [12:0] stepIdx;
  logic [LEDS-1:0] frame;
  logic goS1, goS2, goS3;
  logic goRise;
  logic [7:0] oscAcc;
  logic oscTick;
  logic [15:0] preCnt;
  logic exS1, exS2, exS3;
  logic patTick;
  logic [31:0] wdCnt;
  logic [31:0] wdLimit;
  logic [7:0] durClamp;
  logic [31:0] missCnt;
  logic faultWd, faultClk, faultShort;
  logic ownFault, haltReq;
  logic [3:0] shortCnt [LEDS];
  logic [LEDS-1:0] shortSeen;
  logic [7:0] pwmCnt;
  logic [15:0] muxCnt;
  logic muxPhase;
  logic bankWr, faultClr;
  lap_bank_cfg_t cur;
  logic [15:0] stepAddr;
  logic rxS1, rxS2;
  logic [15:0] rxCnt;
  logic [3:0] rxBit;
  logic [7:0] rxShift;
  logic rxBusy, rxDone;
  logic addrTaken;
  logic [15:0] txCnt;
  logic [3:0] txBit;
  logic [9:0] txShift;
  logic txBusy;

  // the reset pin's pull-up sits in the pad; here it simply joins the core reset
  assign intRst = rst | ~resetPinN; // see (R17)
  assign faultClr = regWr && regAddr == REG_CTRL && regWdata[4];
  assign bankWr = regWr && regAddr[7:4] == REG_BANK0[7:4] && regAddr[1:0] == 2'b00;
  assign cur = bankCfg[bank];

  // software registers
  always_ff @(posedge clk) begin
    if (intRst) begin
      ctrl <= '0;
      prescale <= PRESCALE_RST;
      duty <= DUTY_RST;
    end else if (regWr) begin
      case (regAddr)
        REG_CTRL: ctrl <= lap_ctrl_t'(regWdata[3:0]);
        REG_PRESCALE: prescale <= regWdata[15:0]; // see (R7)
        REG_DUTY: duty <= regWdata[7:0]; // see (R19)
        default: ;
      endcase
    end
  end

  // per-bank play mode, step count and duration
  always_ff @(posedge clk) begin
    if (intRst) begin
      for (int i = 0; i < BANKS; i++) begin
        bankCfg[i] <= '0;
      end
    end else if (bankWr) begin
      bankCfg[regAddr[3:2]] <= lap_bank_cfg_t'(regWdata[21:0]); // see (R14)
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (intRst) begin
      regRdata <= '0;
    end else if (regRd) begin
      regRdata <= '0;
      case (regAddr)
        REG_CTRL: regRdata <= {28'h0, ctrl};
        REG_PRESCALE: regRdata <= {16'h0, prescale};
        REG_DUTY: regRdata <= {24'h0, duty};
        REG_STATUS: regRdata <= {24'h0, status};
        REG_LOADPTR: regRdata <= {16'h0, loadPtr};
        REG_DEVADDR: regRdata <= {24'h0, devAddr};
        default: begin
          if (regAddr[7:4] == REG_BANK0[7:4]) begin
            regRdata <= {10'h0, bankCfg[regAddr[3:2]]};
          end
        end
      endcase
    end
  end

  assign status = '{loadMode: flash_load_mode, bank: bank, faultShort: faultShort,
                    faultClk: faultClk, faultWd: faultWd, ended: animation_end_out,
                    playing: state == LAP_PLAY};

  // go pin edge; stage one only feeds stage two
  always_ff @(posedge clk) begin
    if (intRst) begin
      goS1 <= 1'b0;
      goS2 <= 1'b0;
      goS3 <= 1'b0;
    end else begin
      goS1 <= animation_go_in;
      goS2 <= goS1;
      goS3 <= goS2;
    end
  end
  assign goRise = goS2 & ~goS3; // see (R21)

  // internal oscillator tick at 16/100 of the core rate, then the prescaler
  always_ff @(posedge clk) begin
    if (intRst) begin
      oscAcc <= '0;
      oscTick <= 1'b0;
      preCnt <= '0;
    end else begin
      oscTick <= 1'b0;
      if (oscAcc + OSC_STEP >= OSC_WRAP) begin
        oscAcc <= oscAcc + OSC_STEP - OSC_WRAP;
        oscTick <= 1'b1;
      end else begin
        oscAcc <= oscAcc + OSC_STEP;
      end
      if (oscTick) begin
        preCnt <= (preCnt >= prescale) ? '0 : preCnt + 16'h0001; // see (R7)
      end
    end
  end

  // external pattern clock, rising edges after two-stage capture
  always_ff @(posedge clk) begin
    if (intRst) begin
      exS1 <= 1'b0;
      exS2 <= 1'b0;
      exS3 <= 1'b0;
    end else begin
      exS1 <= external_pattern_clock;
      exS2 <= exS1;
      exS3 <= exS2;
    end
  end
  // external rate is the source's duty; only its absence is policed here
  assign patTick = ctrl.extClk ? (exS2 & ~exS3) // see (R6)
                               : (oscTick && preCnt >= prescale);

  // watchdog limit: clamped duration plus one unit of slack
  assign durClamp = (cur.duration < DUR_MIN) ? DUR_MIN :
                    (cur.duration > DUR_MAX) ? DUR_MAX : cur.duration; // see (R8)
  assign wdLimit = 32'((durClamp + 8'h01) * DUR_CYC);

  // animation watchdog: late end and missing pattern clock
  always_ff @(posedge clk) begin
    if (intRst) begin
      wdCnt <= '0;
      missCnt <= '0;
      faultWd <= 1'b0;
      faultClk <= 1'b0;
    end else begin
      wdCnt <= (state == LAP_PLAY) ? wdCnt + 32'h1 : '0;
      missCnt <= (state != LAP_PLAY || patTick) ? '0 : missCnt + 32'h1;
      if (state == LAP_PLAY && wdCnt >= wdLimit) begin
        faultWd <= 1'b1; // see (R9)
      end else if (faultClr) begin
        faultWd <= 1'b0;
      end
      if (state == LAP_PLAY && missCnt >= 32'(MISS_CYC)) begin
        faultClk <= 1'b1; // see (R10)
      end else if (faultClr) begin
        faultClk <= 1'b0;
      end
    end
  end

  // short: an output driven high that reads back low, filtered per channel
  always_ff @(posedge clk) begin
    if (intRst) begin
      for (int i = 0; i < LEDS; i++) begin
        shortCnt[i] <= '0;
      end
      faultShort <= 1'b0;
    end else begin
      for (int i = 0; i < LEDS; i++) begin
        if (led_drive_outputs[i] && !ledSense[i]) begin
          shortCnt[i] <= (shortCnt[i] == SHORT_FILT) ? shortCnt[i] : shortCnt[i] + 4'h1;
        end else begin
          shortCnt[i] <= '0;
        end
      end
      if (|shortSeen) begin
        faultShort <= 1'b1; // see (R11)
      end else if (faultClr) begin
        faultShort <= 1'b0;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < LEDS; i++) begin
      shortSeen[i] = shortCnt[i] == SHORT_FILT;
    end
  end

  // fault line only ever pulled low, never driven high
  assign ownFault = faultWd | faultClk | faultShort;
  assign faultLineOut = 1'b0;
  assign faultLineOeN = ~ownFault; // see (R12)
  // all-stop devices also obey a neighbour's fault on the shared line
  assign haltReq = ownFault | (ctrl.allStop & ~fault_line_n); // see (R13) (R22)

  // playback sequencer
  always_ff @(posedge clk) begin
    if (intRst) begin
      state <= LAP_IDLE;
      bank <= '0;
      stepIdx <= '0;
      frame <= '0;
      animation_end_out <= 1'b0;
    end else if (!enable || flash_load_mode) begin
      state <= LAP_IDLE; // see (R16) (R4)
      frame <= '0;
      animation_end_out <= 1'b0;
    end else if (haltReq && state == LAP_PLAY) begin
      state <= LAP_HALT; // see (R13)
    end else begin
      case (state)
        LAP_IDLE, LAP_DONE, LAP_HALT: begin
          if (goRise && !haltReq) begin
            bank <= {pattern_pick_1, pattern_pick_0}; // see (R2) (R3) (R21)
            stepIdx <= '0;
            animation_end_out <= 1'b0;
            state <= LAP_PLAY;
          end
        end
        LAP_PLAY: begin
          if (patTick) begin
            frame <= {mem[stepAddr + 16'h1][3:0], mem[stepAddr]};
            stepIdx <= stepIdx + 13'h1;
            if (stepIdx + 13'h1 >= cur.steps) begin
              animation_end_out <= 1'b1; // see (R1) (R15)
              state <= LAP_DONE;
            end
          end
        end
        default: state <= LAP_IDLE;
      endcase
    end
  end
  assign stepAddr = 16'(bank * BANK_BYTES) + {2'b00, stepIdx, 1'b0};

  // dimming counter and multiplex phase
  always_ff @(posedge clk) begin
    if (intRst) begin
      pwmCnt <= '0;
      muxCnt <= '0;
      muxPhase <= 1'b0;
    end else begin
      pwmCnt <= pwmCnt + 8'h01;
      if (muxCnt >= MUX_HALF_CYC) begin
        muxCnt <= '0;
        muxPhase <= ~muxPhase;
      end else begin
        muxCnt <= muxCnt + 16'h0001;
      end
    end
  end

  // output stage; a finished cascade step goes dark, a synchronous one holds
  always_ff @(posedge clk) begin
    logic [LEDS-1:0] lit;
    lit = '0;
    if (intRst) begin
      led_drive_outputs <= '0;
    end else begin
      if (state == LAP_PLAY || state == LAP_HALT || (state == LAP_DONE && !cur.cascade)) begin
        lit = (pwmCnt < duty || duty == DUTY_RST) ? frame : '0; // see (R19) (R14)
      end
      case (ctrl.drive)
        LAP_DRV_CATHODE: led_drive_outputs <= lit; // see (R18)
        LAP_DRV_ANODE: led_drive_outputs <= ~lit;
        LAP_DRV_MUX: led_drive_outputs <= muxPhase ? {4'h0, 2'b10, lit[11:6]}
                                                   : {4'h0, 2'b01, lit[5:0]};
        default: led_drive_outputs <= '0;
      endcase
    end
  end

  // programming receiver on pick pin 0, sampled mid-bit
  always_ff @(posedge clk) begin
    if (intRst) begin
      rxS1 <= 1'b1;
      rxS2 <= 1'b1;
      rxCnt <= '0;
      rxBit <= '0;
      rxShift <= '0;
      rxBusy <= 1'b0;
      rxDone <= 1'b0;
    end else begin
      rxS1 <= pattern_pick_0;
      rxS2 <= rxS1;
      rxDone <= 1'b0;
      if (!flash_load_mode) begin
        rxBusy <= 1'b0;
      end else if (!rxBusy) begin
        if (!rxS2) begin
          rxBusy <= 1'b1;
          rxCnt <= 16'(UART_BIT / 2);
          rxBit <= '0;
        end
      end else if (rxCnt == 16'(UART_BIT - 1)) begin
        rxCnt <= '0;
        rxBit <= rxBit + 4'h1;
        if (rxBit == 4'h0 && rxS2) begin
          rxBusy <= 1'b0; // false start
        end else if (rxBit == 4'h9) begin
          rxBusy <= 1'b0;
          rxDone <= rxS2; // see (R20) bad stop bit drops the byte
        end else if (rxBit != 4'h0) begin
          rxShift <= {rxS2, rxShift[7:1]}; // see (R20)
        end
      end else begin
        rxCnt <= rxCnt + 16'h0001; // see (R5)
      end
    end
  end

  // first byte after entering load mode sets the device address, rest go to flash
  always_ff @(posedge clk) begin
    if (intRst) begin
      devAddr <= DEVADDR_RST;
      addrTaken <= 1'b0;
      loadPtr <= '0;
    end else begin
      if (!flash_load_mode) begin
        addrTaken <= 1'b0;
      end
      if (regWr && regAddr == REG_LOADPTR) begin
        loadPtr <= regWdata[15:0];
      end else if (regWr && regAddr == REG_DEVADDR) begin
        devAddr <= regWdata[7:0];
      end else if (rxDone && !addrTaken) begin
        devAddr <= rxShift; // see (R5)
        addrTaken <= 1'b1;
      end else if (rxDone) begin
        loadPtr <= (loadPtr == 16'(MEM_BYTES - 1)) ? '0 : loadPtr + 16'h0001;
      end
    end
  end

  // pattern store writes; no reset so it maps onto block memory
  always_ff @(posedge clk) begin
    if (rxDone && addrTaken) begin
      mem[loadPtr] <= rxShift; // see (R3)
    end
  end

  // transmitter on pick pin 1 echoes as acknowledge each byte received while it is idle
  always_ff @(posedge clk) begin
    if (intRst) begin
      txCnt <= '0;
      txBit <= '0;
      txShift <= '1;
      txBusy <= 1'b0;
    end else if (!flash_load_mode) begin
      txBusy <= 1'b0;
      txShift <= '1;
    end else if (!txBusy) begin
      if (rxDone) begin
        txShift <= {1'b1, rxShift, 1'b0}; // see (R20)
        txBusy <= 1'b1;
        txCnt <= '0;
        txBit <= '0;
      end
    end else if (txCnt == 16'(UART_BIT - 1)) begin
      txCnt <= '0;
      txShift <= {1'b1, txShift[9:1]};
      txBit <= txBit + 4'h1;
      txBusy <= txBit != 4'h9;
    end else begin
      txCnt <= txCnt + 16'h0001;
    end
  end
  assign pattern_pick_1Out = txShift[0];
  assign pattern_pick_1OeN = ~flash_load_mode; // see (R4)

endmodule

// >>> verification/lap_ctrl_properties.sv
// lap_ctrl_properties: port-level checks for the playback block
// assumes one clock domain; bound to every lap_ctrl instance
`timescale 1ns/100ps
module lap_ctrl_properties
  import lap_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic resetPinN,
  // pins
  input wire logic animation_go_in,
  input wire logic flash_load_mode,
  input wire logic enable,
  input wire logic animation_end_out,
  input wire logic pattern_pick_1OeN,
  input wire logic fault_line_n,
  input wire logic faultLineOut,
  input wire logic faultLineOeN,
  input wire logic [LEDS-1:0] led_drive_outputs,
  input wire logic [LEDS-1:0] ledSense,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr
);
  logic [4:0] shortCnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst || !resetPinN);
  // consecutive cycles with output 0 driven high but reading low
  always_ff @(posedge clk) begin
    if (rst || !resetPinN || !led_drive_outputs[0] || ledSense[0]) begin
      shortCnt <= 5'h00;
    end else if (shortCnt != 5'h1F) begin
      shortCnt <= shortCnt + 5'h01;
    end
  end
  a_line_never_high: assert property (faultLineOut == 1'b0)
    else $error("fault line driven high");
  a_short_reported: assert property (shortCnt == 5'h12 |-> !faultLineOeN)
    else $error("short not reported");
  a_fault_sticky: assert property (
    !faultLineOeN && !(regWr && regAddr == REG_CTRL && regWdata[4]) |=> !faultLineOeN)
    else $error("fault dropped without clear");
  a_go_restarts: assert property (
    $rose(animation_go_in) && animation_end_out && enable && !flash_load_mode
      && faultLineOeN && fault_line_n |-> ##[1:6] !animation_end_out)
    else $error("go rise did not restart");
  a_end_holds: assert property (
    (!animation_go_in) [*3] ##0 (animation_end_out && enable && !flash_load_mode)
      |=> animation_end_out)
    else $error("end output dropped");
  a_low_power_idle: assert property ($past(!enable) |-> !animation_end_out)
    else $error("end high in low power");
  a_load_idle: assert property ($past(flash_load_mode) |-> !animation_end_out)
    else $error("end high in load mode");
  a_tx_load_only: assert property (!pattern_pick_1OeN |-> flash_load_mode)
    else $error("tx driven outside load mode");
  a_pin_reset: assert property (
    disable iff (rst) !resetPinN |=> faultLineOeN && !animation_end_out)
    else $error("reset pin ignored");
  c_end_seen: cover property ($rose(animation_end_out));
  c_fault_seen: cover property ($fell(faultLineOeN));
  c_load_drive: cover property (!pattern_pick_1OeN);
endmodule

bind lap_ctrl lap_ctrl_properties u_props (
  .clk(clk),
  .rst(rst),
  .resetPinN(resetPinN),
  .animation_go_in(animation_go_in),
  .flash_load_mode(flash_load_mode),
  .enable(enable),
  .animation_end_out(animation_end_out),
  .pattern_pick_1OeN(pattern_pick_1OeN),
  .fault_line_n(fault_line_n),
  .faultLineOut(faultLineOut),
  .faultLineOeN(faultLineOeN),
  .led_drive_outputs(led_drive_outputs),
  .ledSense(ledSense),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regWr(regWr)
);

// >>> verification/lap_far_end.sv
// lap_far_end: led loads and a neighbouring device on the fault wire
// assumes the bench forces shorts and neighbour faults on purpose
`timescale 1ns/100ps
module lap_far_end
  import lap_pkg::*;
(
  // from the device
  input wire logic [LEDS-1:0] leds,
  input wire logic faultLineOeN,
  // bench controls
  input wire logic [LEDS-1:0] shortMask,
  input wire logic otherFault,
  // to the device
  output logic [LEDS-1:0] ledSense,
  output logic faultWire
);
  // a shorted output reads low whatever is driven
  assign ledSense = leds & ~shortMask;
  // pulled-up wire; any party may pull it low, neighbour included
  assign faultWire = !(!faultLineOeN || otherFault);
endmodule

// >>> verification/lap_ctrl_tb.sv
// lap_ctrl_tb: register, pin and link scenarios for the playback block
// assumes shortened counts; external pattern clock still outside its own scenario
`timescale 1ns/100ps
module lap_ctrl_tb;
  import lap_pkg::*;
  localparam int UB = 16;
  localparam int DC = 50;
  localparam int MC = 2000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic resetPinN = 1'b1;
  logic go = 1'b0;
  logic pick0 = 1'b0;
  logic pick1Host = 1'b0;
  logic loadMode = 1'b0;
  logic enable = 1'b1;
  logic [11:0] shortMask = 12'h000;
  logic otherFault = 1'b0;
  logic extClkPin = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] pat [4] = '{8'h12, 8'h03, 8'hA5, 8'h0C};
  logic [7:0] echo;
  wire logic pick1Wire, pick1Out, pick1OeN, endOut, faultWire, faultOeN;
  wire logic [11:0] leds, sense;
  wire logic [31:0] regRdata;
  int mismatches = 0;
  int compares = 0;
  always #5 clk = ~clk;
  // released pin shows the host level; device drives it in load mode
  assign pick1Wire = pick1OeN ? pick1Host : pick1Out;
  lap_ctrl #(.UART_BIT(UB), .DUR_CYC(DC), .MISS_CYC(MC)) DUT (
    .clk(clk), .rst(rst), .resetPinN(resetPinN),
    .animation_go_in(go), .pattern_pick_0(pick0), .pattern_pick_1(pick1Wire),
    .pattern_pick_1Out(pick1Out), .pattern_pick_1OeN(pick1OeN),
    .flash_load_mode(loadMode), .external_pattern_clock(extClkPin), .enable(enable),
    .animation_end_out(endOut), .fault_line_n(faultWire), .faultLineOut(),
    .faultLineOeN(faultOeN), .led_drive_outputs(leds), .ledSense(sense),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));
  lap_far_end farEnd (.leds(leds), .faultLineOeN(faultOeN), .shortMask(shortMask),
    .otherFault(otherFault), .ledSense(sense), .faultWire(faultWire));
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // read data appears in the cycle after the strobe and holds until the next read
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(what, exp, regRdata & m);
  endtask
  task automatic uartTx(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      pick0 <= f[i];
      repeat (UB - 1) @(posedge clk);
    end
  endtask
  task automatic uartRx(output logic [7:0] b);
    int n;
    n = 0;
    while (pick1Wire !== 1'b0 && n < 40 * UB) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40 * UB) begin
      mismatches++;
      $display("wrong value echo start: expected 0 seen %b", pick1Wire);
      test_done();
    end
    repeat (UB / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (UB) @(posedge clk);
      b[i] = pick1Wire;
    end
  endtask
  task automatic waitEnd();
    int n;
    n = 0;
    while (endOut !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 300) begin
        mismatches++;
        $display("wrong value end wait: expected 1 seen %b", endOut);
        test_done();
      end
    end
    // outputs launched at this edge settle just after it
    #1;
  endtask
  // go must fall before a new rise counts
  task automatic start();
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    go <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdChk("prescale", REG_PRESCALE, 32'hFFFF, 32'hFFFF);
    rdChk("duty", REG_DUTY, 32'hFF, 32'hFF);
    rdChk("status", REG_STATUS, 32'hFF, 32'h0);
    rdChk("unmapped", 8'h3C, 32'hFFFF_FFFF, 32'h0);
    // load bank 1 over the serial link
    wr(REG_LOADPTR, 32'h3000);
    @(posedge clk);
    pick0 <= 1'b1;
    // idle line must reach the receiver's capture stages before load mode
    repeat (3) @(posedge clk);
    loadMode <= 1'b1;
    repeat (4) @(posedge clk);
    chk("tx enable", 32'h0, {31'h0, pick1OeN});
    rdChk("load status", REG_STATUS, 32'h80, 32'h80);
    fork
      uartTx(8'h5A);
      uartRx(echo);
    join
    chk("echo", 32'h5A, {24'h0, echo});
    foreach (pat[i]) uartTx(pat[i]);
    rdChk("address", REG_DEVADDR, 32'hFF, 32'h5A);
    @(posedge clk);
    loadMode <= 1'b0;
    // synchronous play of bank 1, two steps
    wr(REG_PRESCALE, 32'h0);
    wr(REG_BANK0 + 8'h04, 32'h0000_0201);
    start();
    waitEnd();
    chk("frame", 32'hCA5, {20'h0, leds});
    rdChk("ended", REG_STATUS, 32'hFF, 32'h22);
    // short on a lit output, then clear
    @(posedge clk);
    shortMask <= 12'h001;
    repeat (20) @(posedge clk);
    chk("fault pin", 32'h0, {31'h0, faultOeN});
    rdChk("short", REG_STATUS, 32'h10, 32'h10);
    @(posedge clk);
    shortMask <= 12'h000;
    wr(REG_CTRL, 32'h10);
    #1;
    chk("fault release", 32'h1, {31'h0, faultOeN});
    // cascade play goes dark after its end
    wr(REG_BANK0 + 8'h04, 32'h0020_0201);
    start();
    waitEnd();
    repeat (2) @(posedge clk);
    #1;
    chk("cascade dark", 32'h0, {20'h0, leds});
    @(posedge clk);
    enable <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("low power", 32'h0, {31'h0, endOut});
    @(posedge clk);
    enable <= 1'b1;
    // slow pattern clock: late end and missing tick
    // long duration so the missing tick trips before the watchdog limit
    wr(REG_PRESCALE, 32'hFFFF);
    wr(REG_BANK0 + 8'h04, 32'h0000_0296);
    start();
    repeat (MC + 10) @(posedge clk);
    rdChk("clock lost", REG_STATUS, 32'hC, 32'h8);
    wr(REG_CTRL, 32'h10);
    wr(REG_BANK0 + 8'h04, 32'h0000_0201);
    start();
    repeat (2 * DC + 10) @(posedge clk);
    rdChk("watchdog", REG_STATUS, 32'h4, 32'h4);
    @(posedge clk);
    go <= 1'b0;
    resetPinN <= 1'b0;
    repeat (2) @(posedge clk);
    resetPinN <= 1'b1;
    #1;
    chk("pin reset", 32'h1, {31'h0, faultOeN});
    rdChk("pin reset status", REG_STATUS, 32'hFF, 32'h0);
    // neighbour fault blocks a go rise from starting play in all-stop option
    wr(REG_CTRL, 32'h2);
    wr(REG_PRESCALE, 32'h0);
    wr(REG_BANK0 + 8'h04, 32'h0000_0201);
    @(posedge clk);
    otherFault <= 1'b1;
    start();
    rdChk("all stop", REG_STATUS, 32'h3, 32'h0);
    @(posedge clk);
    otherFault <= 1'b0;
    start();
    waitEnd();
    // external pattern clock: each rising edge plays one step
    wr(REG_CTRL, 32'h1);
    start();
    for (int i = 0; i < 8; i++) begin
      repeat (4) @(posedge clk);
      extClkPin <= ~extClkPin;
    end
    waitEnd();
    chk("ext end", 32'h1, {31'h0, endOut});
    test_done();
  end
endmodule
